/* File: abm_consts.svh */
// Purpose: Shared constants for both ends of the asynchronous bus.
// Assumes: 50 MHz system clock; all pin levels active low unless named rw.
// Notes: Timing counts derive from times in nanoseconds.
// Notes on behaviour
// - Device raises bus error when nobody answers.
// - Bus error retries with halt, else reports error; a second in a row faults.
// - Masters may request the bus anytime.
// - Device grants bus, releasing after current cycle.
// - Grant acknowledge only after grant, bus quiet.
// - Negated grant acknowledge gives two-wire arbitration.
// - Data bus is 16 bits, word or byte.
// - Interrupt vector returns on low data byte.
// - Acknowledge latches read data, ends cycle.
// - Device acknowledges its own internal-type cycles.
// - Fifteen-bit DRAM address shown during row strobe.
// - Function code valid while address strobe asserted.
// - External halt stops bus after cycle ends.
// - Double fault asserts halt until reset.
// - Read takes data, write drives data.
// - Strobes decoded even under another master.
// - Strobes select upper, lower or whole word.
// - Byte writes duplicate data onto other lane.
// - Upper write strobe from write and upper strobe.
// - Lower write strobe from write and lower strobe.
// - Output enable from read and any strobe.
// - Address strobe only with valid address.
`ifndef ABM_CONSTS_SVH
`define ABM_CONSTS_SVH
`define ABM_DATA_W       16
`define ABM_ADDR_W       23
`define ABM_DRAM_W       15
`define ABM_FC_W         3
`define ABM_SYNC_N       5
`define ABM_CLK_NS       20
`define ABM_TIMEOUT_NS   10000
`define ABM_TIMEOUT_CYC  (`ABM_TIMEOUT_NS / `ABM_CLK_NS)
`define ABM_TMR_W        16
`define ABM_ACK_DELAY    8'h02
`define ABM_FC_CPU       3'h7
`endif

/* File: abm_pkg.sv */
// Purpose: Types shared by both ends.
// Assumes: Constants come from abm_consts.svh.
// Notes: Function codes carry their bus encodings.
package abm_pkg;
	typedef enum logic [2:0] {
		ABM_FC_USER_DATA = 3'h1,
		ABM_FC_USER_PROG = 3'h2,
		ABM_FC_SUPV_DATA = 3'h5,
		ABM_FC_SUPV_PROG = 3'h6,
		ABM_FC_CPU_SPACE = 3'h7
	} abm_fc_t;
	typedef enum {DEV_IDLE, DEV_ADDR, DEV_WAIT, DEV_END, DEV_HALT, DEV_GRANT, DEV_FAULT} abm_dev_state_t;
	typedef enum {MST_IDLE, MST_REQ, MST_OWN} abm_mst_state_t;
endpackage

/* File: abm_bus_if.sv */
// Purpose: Pin-level carrier joining the device and the far party.
// Assumes: Undriven lines float high through pull-ups.
// Notes: Open-drain lines are low when either side enables a low drive.
`include "abm_consts.svh"
interface abm_bus_if;
	// Device drives.
	logic                    devBusOe;
	logic                    devAsO;
	logic                    devUdsO;
	logic                    devLdsO;
	logic                    devRwO;
	logic                    devDataOe;
	logic [`ABM_DATA_W-1:0]  devDataO;
	logic                    devDtackO, devDtackOe;
	logic                    devBerrO, devBerrOe;
	logic                    devHaltO, devHaltOe;
	logic                    busGrantN;
	logic [`ABM_FC_W-1:0]    functionCode;
	logic [`ABM_ADDR_W:1]    addr;
	logic                    outEnableN, upperWriteStrobeN, lowerWriteStrobeN;
	logic                    rowStrobeN;
	logic [`ABM_DRAM_W-1:0]  dramRowColAddress;
	// Far party drives.
	logic                    parBusOe;
	logic                    parAsO, parUdsO, parLdsO, parRwO;
	logic                    parDataOe;
	logic [`ABM_DATA_W-1:0]  parDataO;
	logic                    parDtackO, parDtackOe;
	logic                    parBerrO, parBerrOe;
	logic                    parHaltO, parHaltOe;
	logic                    parBrO, parBrOe;
	logic                    parBgackO, parBgackOe;
	// Resolved line levels.
	logic                    addressStrobeN, upperDataStrobeN, lowerDataStrobeN, rw;
	logic [`ABM_DATA_W-1:0]  data;
	logic                    transferAcknowledgeN, busErrorLineN, haltN;
	logic                    busRequestN, grantAcknowledgeN;

	assign addressStrobeN = devBusOe ? devAsO : (parBusOe ? parAsO : 1'b1);
	assign upperDataStrobeN = devBusOe ? devUdsO : (parBusOe ? parUdsO : 1'b1);
	assign lowerDataStrobeN = devBusOe ? devLdsO : (parBusOe ? parLdsO : 1'b1);
	assign rw = devBusOe ? devRwO : (parBusOe ? parRwO : 1'b1);
	assign data = devDataOe ? devDataO : (parDataOe ? parDataO : 16'hFFFF);
	assign transferAcknowledgeN = !((devDtackOe && !devDtackO) || (parDtackOe && !parDtackO));
	assign busErrorLineN = !((devBerrOe && !devBerrO) || (parBerrOe && !parBerrO));
	assign haltN = !((devHaltOe && !devHaltO) || (parHaltOe && !parHaltO));
	assign busRequestN = !(parBrOe && !parBrO);
	assign grantAcknowledgeN = !(parBgackOe && !parBgackO);

	modport device (
		output devBusOe, devAsO, devUdsO, devLdsO, devRwO, devDataOe, devDataO,
		output devDtackO, devDtackOe, devBerrO, devBerrOe, devHaltO, devHaltOe,
		output busGrantN, functionCode, addr, outEnableN, upperWriteStrobeN,
		output lowerWriteStrobeN, rowStrobeN, dramRowColAddress,
		input addressStrobeN, upperDataStrobeN, lowerDataStrobeN, rw, data,
		input transferAcknowledgeN, busErrorLineN, haltN, busRequestN, grantAcknowledgeN
	);
	modport partner (
		output parBusOe, parAsO, parUdsO, parLdsO, parRwO, parDataOe, parDataO,
		output parDtackO, parDtackOe, parBerrO, parBerrOe, parHaltO, parHaltOe,
		output parBrO, parBrOe, parBgackO, parBgackOe,
		input busGrantN, functionCode, addr, outEnableN, upperWriteStrobeN, lowerWriteStrobeN,
		input addressStrobeN, upperDataStrobeN, lowerDataStrobeN, rw, data,
		input transferAcknowledgeN, busErrorLineN, haltN, busRequestN, grantAcknowledgeN
	);
endinterface

/* File: abm_device.sv */
// Purpose: Bus master end of the processor: cycles, arbitration, halt, strobes.
// Assumes: One request at a time; requester waits for rspValid.
// Notes: Control lines are driven inactive high when halted, released when granted.
`include "abm_consts.svh"
module abm_device
	import abm_pkg::*;
(
	// Clock and reset.
	input  wire logic                   clk,
	input  wire logic                   rst,
	// Bus pins.
	abm_bus_if.device                   bus,
	// Request side.
	input  wire logic                   reqValid,
	input  wire logic                   reqWrite,
	input  wire logic [`ABM_ADDR_W:1]   reqAddr,
	input  wire abm_fc_t                reqFc,
	input  wire logic                   reqUpper,
	input  wire logic                   reqLower,
	input  wire logic [`ABM_DATA_W-1:0] reqData,
	input  wire logic                   reqSelfAck,
	input  wire logic                   reqDram,
	output logic                        reqReady,
	// Answer side.
	output logic                        rspValid,
	output logic [`ABM_DATA_W-1:0]      rspData,
	output logic                        rspError,
	output logic                        halted,
	output logic                        faulted
);
	abm_dev_state_t                    state_q;
	logic [`ABM_SYNC_N-1:0]            syncA_q, syncB_q;
	logic                              brLow, bgackLow, dtackLow, berrLow, haltLow;
	logic [`ABM_TMR_W-1:0]             tmr_q;
	logic                              write_q, upper_q, lower_q, selfAck_q, dram_q;
	logic [`ABM_ADDR_W:1]              addr_q;
	logic [`ABM_FC_W-1:0]              fc_q;
	logic [`ABM_DATA_W-1:0]            wdata_q;
	logic                              retry_q, errPend_q, gotErr_q;
	logic [2:0]                        dec;

	// Returns {outEnableN, upperWriteStrobeN, lowerWriteStrobeN} for given line levels.
	function automatic logic [2:0] strobeDecode(input logic uN, input logic lN, input logic r);
		strobeDecode[2] = !(r && (!uN || !lN));
		strobeDecode[1] = !(!r && !uN);
		strobeDecode[0] = !(!r && !lN);
	endfunction

	// ==========================================================
	// Input synchronisers
	always_ff @(posedge clk) begin
		if (rst) begin
			syncA_q <= 5'h1F;
			syncB_q <= 5'h1F;
		end else begin
			syncA_q <= {bus.busRequestN, bus.grantAcknowledgeN, bus.transferAcknowledgeN,
				bus.busErrorLineN, bus.haltN};
			syncB_q <= syncA_q;
		end
	end
	assign brLow = !syncB_q[4];
	assign bgackLow = !syncB_q[3];
	assign dtackLow = !syncB_q[2];
	assign berrLow = !syncB_q[1];
	assign haltLow = !syncB_q[0];

	// ==========================================================
	// Cycle sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= DEV_IDLE;
			retry_q <= 1'b0;
			errPend_q <= 1'b0;
			gotErr_q <= 1'b0;
			rspValid <= 1'b0;
			rspError <= 1'b0;
			rspData <= 16'h0000;
		end else begin
			rspValid <= 1'b0;
			case (state_q)
				DEV_IDLE: begin
					if (haltLow) begin
						state_q <= DEV_HALT;
					end else if (brLow || bgackLow) begin
						state_q <= DEV_GRANT;
					end else if (reqValid) begin
						state_q <= DEV_ADDR;
					end
				end
				DEV_ADDR: state_q <= DEV_WAIT;
				DEV_WAIT: begin
					if (berrLow) begin
						// Halt seen with bus error means rerun the same cycle.
						retry_q <= haltLow;
						gotErr_q <= 1'b1;
						state_q <= DEV_END;
					end else if (dtackLow) begin
						if (!write_q) begin
							rspData <= bus.data;
						end
						gotErr_q <= 1'b0;
						state_q <= DEV_END;
					end
				end
				DEV_END: begin
					// Wait for both terminators to lift so the next cycle is not ended early.
					if (!dtackLow && !berrLow) begin
						if (retry_q) begin
							state_q <= DEV_HALT;
						end else if (gotErr_q && errPend_q) begin
							state_q <= DEV_FAULT;
						end else begin
							rspValid <= 1'b1;
							rspError <= gotErr_q;
							errPend_q <= gotErr_q;
							state_q <= haltLow ? DEV_HALT : DEV_IDLE;
						end
					end
				end
				DEV_HALT: begin
					if (!haltLow) begin
						retry_q <= 1'b0;
						state_q <= retry_q ? DEV_ADDR : DEV_IDLE;
					end
				end
				DEV_GRANT: begin
					if (!brLow && !bgackLow) begin
						state_q <= DEV_IDLE;
					end
				end
				DEV_FAULT: state_q <= DEV_FAULT;
				default: state_q <= DEV_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Request capture
	always_ff @(posedge clk) begin
		if (rst) begin
			write_q <= 1'b0;
			upper_q <= 1'b0;
			lower_q <= 1'b0;
			selfAck_q <= 1'b0;
			dram_q <= 1'b0;
			addr_q <= 23'h000000;
			fc_q <= 3'h0;
			wdata_q <= 16'h0000;
			reqReady <= 1'b0;
		end else begin
			reqReady <= (state_q == DEV_IDLE) && !haltLow && !brLow && !bgackLow && !reqValid;
			if (state_q == DEV_IDLE && reqValid && !haltLow && !brLow && !bgackLow) begin
				write_q <= reqWrite;
				upper_q <= reqUpper;
				lower_q <= reqLower;
				selfAck_q <= reqSelfAck;
				dram_q <= reqDram;
				addr_q <= reqAddr;
				fc_q <= reqFc;
				// Single-byte writes copy the byte onto both lanes.
				case ({reqUpper, reqLower})
					2'b01: wdata_q <= {reqData[7:0], reqData[7:0]};
					2'b10: wdata_q <= {reqData[15:8], reqData[15:8]};
					default: wdata_q <= reqData;
				endcase
			end
		end
	end

	// ==========================================================
	// No-response timer
	always_ff @(posedge clk) begin
		if (rst) begin
			tmr_q <= 16'h0000;
		end else if (state_q == DEV_WAIT && tmr_q != 16'(`ABM_TIMEOUT_CYC)) begin
			tmr_q <= tmr_q + 16'h0001;
		end else if (state_q != DEV_WAIT) begin
			tmr_q <= 16'h0000;
		end
	end

	// ==========================================================
	// Pin drivers
	always_ff @(posedge clk) begin
		if (rst) begin
			bus.devBusOe <= 1'b1;
			bus.devAsO <= 1'b1;
			bus.devUdsO <= 1'b1;
			bus.devLdsO <= 1'b1;
			bus.devRwO <= 1'b1;
			bus.devDataOe <= 1'b0;
			bus.devDataO <= 16'h0000;
			bus.functionCode <= 3'h0;
			bus.addr <= 23'h000000;
			bus.rowStrobeN <= 1'b1;
			bus.dramRowColAddress <= 15'h0000;
		end else begin
			// Bus is released only while another master requests or holds it.
			bus.devBusOe <= (state_q != DEV_GRANT) && !(state_q == DEV_IDLE && (brLow || bgackLow));
			if (state_q == DEV_ADDR || (state_q == DEV_WAIT && !dtackLow && !berrLow)) begin
				bus.devAsO <= 1'b0;
				bus.devUdsO <= !upper_q;
				bus.devLdsO <= !lower_q;
				bus.devRwO <= !write_q;
				bus.devDataOe <= write_q;
				bus.functionCode <= fc_q;
				bus.addr <= addr_q;
				bus.rowStrobeN <= !dram_q;
			end else begin
				bus.devAsO <= 1'b1;
				bus.devUdsO <= 1'b1;
				bus.devLdsO <= 1'b1;
				bus.devRwO <= 1'b1;
				bus.devDataOe <= 1'b0;
				bus.rowStrobeN <= 1'b1;
			end
			bus.devDataO <= wdata_q;
			bus.dramRowColAddress <= addr_q[15:1];
		end
	end

	// ==========================================================
	// Open-drain terminators, arbitration and decoded strobes
	always_ff @(posedge clk) begin
		if (rst) begin
			bus.devDtackOe <= 1'b0;
			bus.devBerrOe <= 1'b0;
			bus.devHaltOe <= 1'b0;
			bus.busGrantN <= 1'b1;
			bus.outEnableN <= 1'b1;
			bus.upperWriteStrobeN <= 1'b1;
			bus.lowerWriteStrobeN <= 1'b1;
			halted <= 1'b0;
			faulted <= 1'b0;
		end else begin
			bus.devDtackOe <= (state_q == DEV_WAIT) && selfAck_q && !berrLow;
			bus.devBerrOe <= (state_q == DEV_WAIT) && (tmr_q == 16'(`ABM_TIMEOUT_CYC));
			bus.devHaltOe <= (state_q == DEV_FAULT);
			bus.busGrantN <= !(brLow && !bgackLow && state_q != DEV_FAULT);
			bus.outEnableN <= dec[2];
			bus.upperWriteStrobeN <= dec[1];
			bus.lowerWriteStrobeN <= dec[0];
			halted <= (state_q == DEV_HALT);
			faulted <= (state_q == DEV_FAULT);
		end
	end
	assign dec = strobeDecode(bus.upperDataStrobeN, bus.lowerDataStrobeN, bus.rw);
	assign bus.devDtackO = 1'b0;
	assign bus.devBerrO = 1'b0;
	assign bus.devHaltO = 1'b0;
endmodule

/* File: abm_partner.sv */
// Purpose: Far party: memory-style responder plus an alternate bus master.
// Assumes: Responder and master are never active in the same cycle.
// Notes: Two-wire mode keeps the request asserted for the whole tenure.
`include "abm_consts.svh"
module abm_partner
	import abm_pkg::*;
(
	// Clock and reset.
	input  wire logic                   clk,
	input  wire logic                   rst,
	// Bus pins.
	abm_bus_if.partner                  bus,
	// Responder control.
	input  wire logic                   ackEnable,
	input  wire logic                   errInject,
	input  wire logic                   haltReq,
	input  wire logic [`ABM_DATA_W-1:0] readData,
	input  wire logic [7:0]             vectorNum,
	output logic                        wrValid,
	output logic [`ABM_DATA_W-1:0]      wrData,
	// Alternate master control.
	input  wire logic                   mstReq,
	input  wire logic                   mstTwoWire,
	input  wire logic                   mstWrite,
	input  wire logic                   mstUpper,
	input  wire logic                   mstLower,
	input  wire logic [`ABM_DATA_W-1:0] mstData,
	output logic                        mstOwned
);
	abm_mst_state_t   mst_q;
	logic [7:0]       dly_q;
	logic             sel;

	assign sel = !bus.addressStrobeN && (!bus.upperDataStrobeN || !bus.lowerDataStrobeN) && mst_q != MST_OWN;

	// ==========================================================
	// Responder
	always_ff @(posedge clk) begin
		if (rst) begin
			dly_q <= 8'h00;
			bus.parDtackOe <= 1'b0;
			bus.parBerrOe <= 1'b0;
			bus.parHaltOe <= 1'b0;
			wrValid <= 1'b0;
			wrData <= 16'h0000;
		end else begin
			bus.parHaltOe <= haltReq;
			wrValid <= 1'b0;
			if (!sel) begin
				dly_q <= 8'h00;
				bus.parDtackOe <= 1'b0;
				bus.parBerrOe <= 1'b0;
			end else if (dly_q != `ABM_ACK_DELAY) begin
				dly_q <= dly_q + 8'h01;
			end else if (!bus.parDtackOe && !bus.parBerrOe) begin
				bus.parBerrOe <= errInject;
				bus.parDtackOe <= ackEnable && !errInject;
				wrValid <= ackEnable && !errInject && !bus.rw;
				wrData <= bus.data;
			end
		end
	end

	// ==========================================================
	// Alternate master
	always_ff @(posedge clk) begin
		if (rst) begin
			mst_q <= MST_IDLE;
			bus.parBrOe <= 1'b0;
			bus.parBgackOe <= 1'b0;
			mstOwned <= 1'b0;
		end else begin
			case (mst_q)
				MST_IDLE: begin
					if (mstReq) begin
						bus.parBrOe <= 1'b1;
						mst_q <= MST_REQ;
					end
				end
				MST_REQ: begin
					if (!mstReq) begin
						bus.parBrOe <= 1'b0;
						mst_q <= MST_IDLE;
					end else if (!bus.busGrantN && bus.addressStrobeN && bus.transferAcknowledgeN
						&& (mstTwoWire || bus.grantAcknowledgeN)) begin
						bus.parBgackOe <= !mstTwoWire;
						bus.parBrOe <= mstTwoWire;
						mstOwned <= 1'b1;
						mst_q <= MST_OWN;
					end
				end
				MST_OWN: begin
					if (!mstReq) begin
						bus.parBrOe <= 1'b0;
						bus.parBgackOe <= 1'b0;
						mstOwned <= 1'b0;
						mst_q <= MST_IDLE;
					end
				end
				default: mst_q <= MST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Pin drivers
	always_ff @(posedge clk) begin
		if (rst) begin
			bus.parBusOe <= 1'b0;
			bus.parAsO <= 1'b1;
			bus.parUdsO <= 1'b1;
			bus.parLdsO <= 1'b1;
			bus.parRwO <= 1'b1;
			bus.parDataOe <= 1'b0;
			bus.parDataO <= 16'h0000;
		end else begin
			// Owner drives once granted with strobe and acknowledge high; it does not check that the device has let go.
			bus.parBusOe <= (mst_q == MST_OWN) && mstReq;
			bus.parAsO <= !(mst_q == MST_OWN && (mstUpper || mstLower));
			bus.parUdsO <= !(mst_q == MST_OWN && mstUpper);
			bus.parLdsO <= !(mst_q == MST_OWN && mstLower);
			bus.parRwO <= !(mst_q == MST_OWN && mstWrite);
			if (mst_q == MST_OWN) begin
				bus.parDataOe <= mstWrite && mstReq;
				bus.parDataO <= mstData;
			end else begin
				bus.parDataOe <= sel && bus.rw;
				if (bus.functionCode == `ABM_FC_CPU) begin
					bus.parDataO <= {8'h00, vectorNum};
				end else begin
					bus.parDataO <= readData;
				end
			end
		end
	end
	assign bus.parDtackO = 1'b0;
	assign bus.parBerrO = 1'b0;
	assign bus.parHaltO = 1'b0;
	assign bus.parBrO = 1'b0;
	assign bus.parBgackO = 1'b0;
endmodule

/* File: abm_asserts.sv */
// Purpose: Concurrent checks on the resolved bus lines between the two ends.
// Assumes: One clock domain; rst is synchronous and active high.
// Notes: Decoded strobes lag the lines by one registered cycle.
`include "abm_consts.svh"
module abm_asserts (
	// Clock and reset.
	input wire logic                   clk,
	input wire logic                   rst,
	// Resolved lines.
	input wire logic                   addressStrobeN,
	input wire logic                   upperDataStrobeN,
	input wire logic                   lowerDataStrobeN,
	input wire logic                   rw,
	input wire logic [`ABM_DATA_W-1:0] data,
	input wire logic                   busRequestN,
	input wire logic                   haltN,
	// Device drives.
	input wire logic                   devBusOe,
	input wire logic                   devDataOe,
	input wire logic                   devBerrO,
	input wire logic                   devBerrOe,
	input wire logic                   devHaltO,
	input wire logic                   devHaltOe,
	input wire logic                   busGrantN,
	input wire logic [`ABM_FC_W-1:0]   functionCode,
	input wire logic                   outEnableN,
	input wire logic                   upperWriteStrobeN,
	input wire logic                   lowerWriteStrobeN
);
	timeunit 1ns / 1ps;
	// ====================================================
	// Helper counters, saturating so that long runs never wrap.
	logic [9:0] asLow_q;
	logic [3:0] haltLow_q;
	always_ff @(posedge clk) asLow_q <= (rst || addressStrobeN) ? 10'h000 : asLow_q + {9'h000, asLow_q != 10'h3FF};
	always_ff @(posedge clk) haltLow_q <= (rst || haltN) ? 4'h0 : haltLow_q + {3'h0, haltLow_q != 4'hF};
	// ====================================================
	// Properties.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_uw; upperWriteStrobeN == ($past(rw) || $past(upperDataStrobeN)); endproperty
	a_uw: assert property (p_uw) else $error("upper write strobe decode wrong");
	property p_lw; lowerWriteStrobeN == ($past(rw) || $past(lowerDataStrobeN)); endproperty
	a_lw: assert property (p_lw) else $error("lower write strobe decode wrong");
	property p_oe; outEnableN == !($past(rw) && !($past(upperDataStrobeN) && $past(lowerDataStrobeN))); endproperty
	a_oe: assert property (p_oe) else $error("output enable decode wrong");
	property p_fc; !addressStrobeN && $past(!addressStrobeN) && devBusOe |-> $stable(functionCode); endproperty
	a_fc: assert property (p_fc) else $error("function code moved while strobe low");
	property p_rd; devBusOe && !addressStrobeN && rw |-> !devDataOe; endproperty
	a_rd: assert property (p_rd) else $error("device drove data during read");
	property p_dup; devDataOe && (upperDataStrobeN != lowerDataStrobeN) |-> data[15:8] == data[7:0]; endproperty
	a_dup: assert property (p_dup) else $error("byte write lanes differ");
	property p_grant; $fell(busRequestN) |-> ##[1:6] !busGrantN; endproperty
	a_grant: assert property (p_grant) else $error("no grant after request");
	property p_tmo; $rose(devBerrOe && !devBerrO) |-> asLow_q >= 10'h1EA; endproperty
	a_tmo: assert property (p_tmo) else $error("bus error raised before timeout");
	property p_halt; haltLow_q == 4'hF && devBusOe && $past(addressStrobeN) |-> addressStrobeN; endproperty
	a_halt: assert property (p_halt) else $error("cycle started while halted");
	property p_fault; devHaltOe && !devHaltO |=> devHaltOe && !devHaltO; endproperty
	a_fault: assert property (p_fault) else $error("halt released after double fault");
endmodule

/* File: abm_tb_top.sv */
// Purpose: Self-checking bench joining the device and the partner on one bus.
// Assumes: Partner answers after its fixed delay; no responder means a 500-cycle wait.
// Notes: Read and write results are compared by value; line timing is left to the checker.
`include "abm_consts.svh"
module abm_tb_top
	import abm_pkg::*;
;
	timeunit 1ns / 1ps;
	logic                   clk = 1'h0, rst = 1'h1, reqValid = 1'h0, reqWrite = 1'h0, reqUpper = 1'h1;
	logic                   reqLower = 1'h1, reqSelfAck = 1'h0, reqDram = 1'h0, ackEnable = 1'h1;
	logic                   errInject = 1'h0, haltReq = 1'h0, mstReq = 1'h0, mstTwoWire = 1'h0, mstWrite = 1'h0;
	logic [`ABM_ADDR_W:1]   reqAddr = 23'h000000;
	logic [`ABM_DATA_W-1:0] reqData = 16'h0000, readData = 16'h0000, lastWr = 16'h0000, wrData, rspData;
	logic [7:0]             vectorNum = 8'h5A;
	abm_fc_t                reqFc = ABM_FC_USER_DATA;
	logic                   reqReady, rspValid, rspError, halted, faulted, wrValid, mstOwned;
	logic [2:0]             seenFc = 3'h0;
	logic [14:0]            seenDram = 15'h0000;
	logic [1:0]             sawMst = 2'h3;
	int                     n_mismatch = 0, checks = 0;
	abm_fc_t                fcs [5] = '{ABM_FC_USER_DATA, ABM_FC_USER_PROG, ABM_FC_SUPV_DATA,
	                                    ABM_FC_SUPV_PROG, ABM_FC_CPU_SPACE};
	// ====================================================
	// Both ends and the checker.
	abm_bus_if busIf ();
	abm_device abm_device_i (.clk(clk), .rst(rst), .bus(busIf), .reqValid(reqValid), .reqWrite(reqWrite),
		.reqAddr(reqAddr), .reqFc(reqFc), .reqUpper(reqUpper), .reqLower(reqLower), .reqData(reqData),
		.reqSelfAck(reqSelfAck), .reqDram(reqDram), .reqReady(reqReady), .rspValid(rspValid),
		.rspData(rspData), .rspError(rspError), .halted(halted), .faulted(faulted));
	abm_partner abm_partner_i (.clk(clk), .rst(rst), .bus(busIf), .ackEnable(ackEnable),
		.errInject(errInject), .haltReq(haltReq), .readData(readData), .vectorNum(vectorNum),
		.wrValid(wrValid), .wrData(wrData), .mstReq(mstReq), .mstTwoWire(mstTwoWire), .mstWrite(mstWrite),
		.mstUpper(1'h1), .mstLower(1'h0), .mstData(16'h3C5A), .mstOwned(mstOwned));
	abm_asserts abm_asserts_i (.clk(clk), .rst(rst), .addressStrobeN(busIf.addressStrobeN),
		.upperDataStrobeN(busIf.upperDataStrobeN), .lowerDataStrobeN(busIf.lowerDataStrobeN),
		.rw(busIf.rw), .data(busIf.data), .busRequestN(busIf.busRequestN), .haltN(busIf.haltN),
		.devBusOe(busIf.devBusOe), .devDataOe(busIf.devDataOe), .devBerrO(busIf.devBerrO),
		.devBerrOe(busIf.devBerrOe), .devHaltO(busIf.devHaltO), .devHaltOe(busIf.devHaltOe),
		.busGrantN(busIf.busGrantN), .functionCode(busIf.functionCode), .outEnableN(busIf.outEnableN),
		.upperWriteStrobeN(busIf.upperWriteStrobeN), .lowerWriteStrobeN(busIf.lowerWriteStrobeN));
	initial forever #10 clk = ~clk;
	// Bus watchers; the master decode bits stay low once seen, until the device drives the bus again.
	always @(posedge clk) begin
		if (wrValid === 1'h1) lastWr <= wrData;
		if (busIf.addressStrobeN === 1'h0 && busIf.devBusOe === 1'h1) seenFc <= busIf.functionCode;
		if (busIf.rowStrobeN === 1'h0) seenDram <= busIf.dramRowColAddress;
		sawMst <= (busIf.devBusOe === 1'h1) ? 2'h3 : sawMst & {busIf.outEnableN, busIf.upperWriteStrobeN};
	end
	// ====================================================
	// Tasks.
	task automatic final_report();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic cmp_bit(input logic got, input logic exp, input string what);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s got %b want %b", $time, what, got, exp);
		end
	endtask
	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	function automatic logic flag(input int sel);
		case (sel)
			0: return rspValid;
			1: return faulted;
			2: return halted;
			3: return mstOwned;
			4: return !busIf.busGrantN;
			5: return !busIf.addressStrobeN;
			6: return reqReady;
			default: return !halted;
		endcase
	endfunction
	task automatic wait_flag(input int sel, input int lim);
		int k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (flag(sel) !== 1'h1 && k < lim);
		if (flag(sel) !== 1'h1) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: wait %0d ran out", $time, sel);
			final_report();
		end
	endtask
	// A request is held for exactly one edge after the device shows it is idle.
	task automatic dev_cycle(input logic w, input logic [`ABM_ADDR_W:1] a, input abm_fc_t f,
	                         input logic [1:0] lanes, input logic [15:0] d, input logic [1:0] own, input logic rsp);
		wait_flag(6, 50);
		{reqValid, reqWrite, reqUpper, reqLower, reqSelfAck, reqDram} <= {1'h1, w, lanes, own};
		{reqAddr, reqData} <= {a, d};
		reqFc <= f;
		@(posedge clk);
		reqValid <= 1'h0;
		if (rsp) wait_flag(0, 700);
	endtask
	// ====================================================
	// Scenarios.
	initial begin
		logic [1:0]  ln;
		logic [15:0] d;
		d = 16'hA5C3;
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 3; i++) begin
			ln = 2'h3 - i[1:0];
			dev_cycle(1'h1, 23'h000100 + i, ABM_FC_SUPV_DATA, ln, d, 2'h0, 1'h1);
			cmp_word(lastWr, ln == 2'h2 ? {2{d[15:8]}} : ln == 2'h1 ? {2{d[7:0]}} : d, "write");
		end
		for (int i = 0; i < 5; i++) begin
			readData <= 16'h1230 + i[15:0];
			dev_cycle(1'h0, 23'h000200 + i, fcs[i], 2'h3, 16'h0000, 2'h0, 1'h1);
			cmp_bit(seenFc === fcs[i], 1'h1, "function code");
			if (i == 4) cmp_word({8'h00, rspData[7:0]}, {8'h00, vectorNum}, "vector");
			else cmp_word(rspData, 16'h1230 + i[15:0], "read");
		end
		ackEnable <= 1'h0;
		dev_cycle(1'h0, 23'h00ABCD, ABM_FC_USER_DATA, 2'h3, 16'h0000, 2'h3, 1'h1);
		cmp_bit(rspError, 1'h0, "self acknowledge");
		cmp_word({1'h0, seenDram}, 16'h2BCD, "dram address");
		dev_cycle(1'h0, 23'h000300, ABM_FC_USER_DATA, 2'h3, 16'h0000, 2'h0, 1'h1);
		cmp_bit(rspError, 1'h1, "no responder");
		ackEnable <= 1'h1;
		dev_cycle(1'h0, 23'h000301, ABM_FC_USER_DATA, 2'h1, 16'h0000, 2'h0, 1'h1);
		cmp_bit(rspError, 1'h0, "read after timeout");
		errInject <= 1'h1;
		dev_cycle(1'h0, 23'h000302, ABM_FC_USER_DATA, 2'h2, 16'h0000, 2'h0, 1'h1);
		cmp_bit(rspError, 1'h1, "external bus error");
		readData <= 16'h4D2E;
		fork
			dev_cycle(1'h0, 23'h000303, ABM_FC_USER_DATA, 2'h3, 16'h0000, 2'h0, 1'h1);
			begin
				wait_flag(5, 60);
				haltReq <= 1'h1;
				wait_flag(2, 100);
				{errInject, haltReq} <= 2'h0;
			end
		join
		cmp_bit(rspError, 1'h0, "retried cycle");
		cmp_word(rspData, 16'h4D2E, "retried data");
		haltReq <= 1'h1;
		wait_flag(2, 20);
		cmp_bit(reqReady, 1'h0, "refused while halted");
		repeat (16) @(posedge clk);
		haltReq <= 1'h0;
		wait_flag(7, 20);
		for (int m = 0; m < 2; m++) begin
			wait_flag(6, 20);
			{mstTwoWire, mstWrite, mstReq} <= {m[0], !m[0], 1'h1};
			wait_flag(4, 20);
			wait_flag(3, 20);
			repeat (4) @(posedge clk);
			cmp_bit(busIf.grantAcknowledgeN, m[0], "grant acknowledge");
			cmp_bit(busIf.devBusOe, 1'h0, "bus released");
			cmp_bit(reqReady, 1'h0, "refused while granted");
			cmp_bit(sawMst[m], 1'h0, "decode under other master");
			mstReq <= 1'h0;
		end
		errInject <= 1'h1;
		dev_cycle(1'h0, 23'h000400, ABM_FC_USER_DATA, 2'h3, 16'h0000, 2'h0, 1'h1);
		cmp_bit(rspError, 1'h1, "first error");
		dev_cycle(1'h0, 23'h000401, ABM_FC_USER_DATA, 2'h3, 16'h0000, 2'h0, 1'h0);
		wait_flag(1, 100);
		cmp_bit(busIf.haltN, 1'h0, "halt driven on double fault");
		cmp_bit(reqReady, 1'h0, "refused while faulted");
		{rst, errInject} <= 2'h2;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		wait_flag(6, 20);
		cmp_bit(faulted, 1'h0, "fault cleared by reset");
		final_report();
	end
endmodule
